//--- rtl/crm_device.sv
`timescale 1ns/1ps
`default_nettype none
`include "crm_params.svh"

module crm_device (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Link
    crm_link_if.dev link,
    // Register access
    output logic reg_req,
    output logic reg_we,
    output crm_pkg::crm_class_t reg_class,
    output logic [15:0] reg_num,
    output logic [31:0] reg_wdata,
    input wire logic reg_ack,
    input wire logic reg_ok,
    input wire logic [31:0] reg_rdata,
    // Processor status access
    input wire logic ps_req,
    input wire logic ps_we,
    input wire logic [7:0] ps_num,
    input wire logic [31:0] ps_wdata,
    output logic ps_ack,
    output logic [31:0] ps_rdata
);
    import crm_pkg::*;

    crm_dstate_t state_reg, state_next;
    logic [71:0] buf_reg, buf_next;
    logic [3:0] cnt_reg, cnt_next;
    logic [7:0] op_reg, op_next;
    logic bad_reg, bad_next;
    logic ok_reg, ok_next;
    logic ps_reg, ps_next;
    logic [7:0] left_reg, left_next;
    logic [2:0] chunk_reg, chunk_next;
    logic [31:0] rdata_reg, rdata_next;
    logic req_ready_reg, req_ready_next;
    logic rsp_valid_reg, rsp_valid_next;
    logic rsp_ctrl_reg, rsp_ctrl_next;
    logic [7:0] rsp_data_reg, rsp_data_next;
    logic [23:0] rsp_dest_reg, rsp_dest_next;
    logic reg_req_reg, reg_req_next;
    logic reg_we_reg, reg_we_next;
    crm_class_t reg_class_reg, reg_class_next;
    logic [15:0] reg_num_reg, reg_num_next;
    logic [31:0] reg_wdata_reg, reg_wdata_next;
    logic ps_ack_reg, ps_ack_next;
    logic [31:0] ps_rdata_reg, ps_rdata_next;

    logic take;
    logic fire;
    logic [1:0] tgt;
    logic [3:0] exp_len;
    logic fail;
    logic [23:0] id_w;

    // ============================================================
    // Target decode from the channel-end destination
    always_comb begin
        tgt = 2'h3;
        if (link.dest[15:0] == `CRM_DST_TILE) begin
            tgt = 2'h0;
        end else if (link.dest[15:0] == `CRM_DST_NODE) begin
            tgt = 2'h1;
        end else if (link.dest[7:0] == `CRM_DST_PERI) begin
            tgt = 2'h2;
        end
    end

    // ============================================================
    // Message control
    always_comb begin
        state_next = state_reg;
        buf_next = buf_reg;
        cnt_next = cnt_reg;
        op_next = op_reg;
        bad_next = bad_reg;
        ok_next = ok_reg;
        ps_next = ps_reg;
        left_next = left_reg;
        chunk_next = chunk_reg;
        rdata_next = rdata_reg;
        rsp_valid_next = rsp_valid_reg & ~link.rsp_ready;
        rsp_ctrl_next = rsp_ctrl_reg;
        rsp_data_next = rsp_data_reg;
        rsp_dest_next = rsp_dest_reg;
        reg_req_next = 1'b0;
        reg_we_next = reg_we_reg;
        reg_class_next = reg_class_reg;
        reg_num_next = reg_num_reg;
        reg_wdata_next = reg_wdata_reg;
        ps_ack_next = 1'b0;
        ps_rdata_next = ps_rdata_reg;
        take = link.req_valid & req_ready_reg;
        fire = ~rsp_valid_reg | link.rsp_ready;
        exp_len = `CRM_CNT_MAX;
        fail = 1'b0;
        id_w = buf_reg[39:16];
        unique case (op_reg)
            `CRM_TOK_CFG_WR: begin
                exp_len = `CRM_LEN_CFG_WR;
                fail = tgt[1];
                id_w = buf_reg[71:48];
            end
            `CRM_TOK_CFG_RD: begin
                exp_len = `CRM_LEN_CFG_RD;
                fail = tgt[1];
            end
            `CRM_TOK_PER_RD: begin
                exp_len = `CRM_LEN_PER_RD;
                fail = (tgt != 2'h2);
            end
            default: fail = 1'b1;
        endcase
        fail = fail | bad_reg | (cnt_reg != exp_len);
        unique case (state_reg)
            CRM_D_IDLE: begin
                if (take && !(link.req_ctrl && link.req_data == `CRM_TOK_END)) begin
                    op_next = link.req_ctrl ? link.req_data : 8'h00;
                    cnt_next = 4'h0;
                    bad_next = 1'b0;
                    state_next = CRM_D_HDR;
                end else if (!link.req_valid && ps_req) begin
                    ps_next = 1'b1;
                    reg_we_next = ps_we;
                    reg_class_next = CRM_CL_PS;
                    reg_num_next = {ps_num, `CRM_PS_TYPE};
                    reg_wdata_next = ps_wdata;
                    state_next = CRM_D_EXEC;
                end
            end
            CRM_D_HDR: begin
                if (take && link.req_ctrl && link.req_data == `CRM_TOK_END) begin
                    ps_next = 1'b0;
                    ok_next = ~fail;
                    rsp_dest_next = id_w;
                    left_next = buf_reg[7:0];
                    reg_we_next = (op_reg == `CRM_TOK_CFG_WR);
                    reg_class_next = crm_class_t'(tgt);
                    reg_num_next = (op_reg == `CRM_TOK_PER_RD) ? {8'h00, buf_reg[15:8]}
                        : (op_reg == `CRM_TOK_CFG_WR) ? buf_reg[47:32] : buf_reg[15:0];
                    reg_wdata_next = buf_reg[31:0];
                    if (!fail) begin
                        state_next = CRM_D_EXEC;
                    end else if (op_reg == `CRM_TOK_CFG_WR && id_w[7:0] == `CRM_NOREPLY) begin
                        state_next = CRM_D_IDLE;
                    end else begin
                        state_next = CRM_D_TOK;
                    end
                end else if (take && link.req_ctrl) begin
                    bad_next = 1'b1;
                end else if (take) begin
                    buf_next = {buf_reg[63:0], link.req_data};
                    if (cnt_reg != `CRM_CNT_MAX) begin
                        cnt_next = cnt_reg + 4'h1;
                    end
                end
            end
            CRM_D_EXEC: begin
                reg_req_next = 1'b1;
                state_next = CRM_D_WAIT;
            end
            CRM_D_WAIT: begin
                if (reg_ack) begin
                    if (ps_reg) begin
                        ps_next = 1'b0;
                        ps_ack_next = 1'b1;
                        ps_rdata_next = reg_rdata;
                        state_next = CRM_D_IDLE;
                    end else if (reg_class_reg == CRM_CL_PERI && left_reg != buf_reg[7:0]) begin
                        rdata_next = {reg_rdata[7:0], 24'h000000};
                        chunk_next = 3'h1;
                        state_next = CRM_D_DATA;
                    end else begin
                        ok_next = reg_ok;
                        rdata_next = (reg_class_reg == CRM_CL_PERI)
                            ? {reg_rdata[7:0], 24'h000000} : reg_rdata;
                        chunk_next = (reg_class_reg == CRM_CL_PERI) ? 3'h1 : 3'h4;
                        if (reg_we_reg && rsp_dest_reg[7:0] == `CRM_NOREPLY) begin
                            state_next = CRM_D_IDLE;
                        end else begin
                            state_next = CRM_D_TOK;
                        end
                    end
                end
            end
            CRM_D_TOK: begin
                if (fire) begin
                    rsp_valid_next = 1'b1;
                    rsp_ctrl_next = 1'b1;
                    rsp_data_next = ok_reg ? `CRM_TOK_ACK : `CRM_TOK_NAK;
                    if (!ok_reg || reg_we_reg) begin
                        state_next = CRM_D_END;
                    end else if (reg_class_reg == CRM_CL_PERI && left_reg == 8'h00) begin
                        state_next = CRM_D_END;
                    end else begin
                        state_next = CRM_D_DATA;
                    end
                end
            end
            CRM_D_DATA: begin
                if (fire) begin
                    rsp_valid_next = 1'b1;
                    rsp_ctrl_next = 1'b0;
                    rsp_data_next = rdata_reg[31:24];
                    rdata_next = {rdata_reg[23:0], 8'h00};
                    chunk_next = chunk_reg - 3'h1;
                    if (reg_class_reg == CRM_CL_PERI) begin
                        left_next = left_reg - 8'h01;
                        reg_num_next = reg_num_reg + 16'h0001;
                        state_next = (left_reg == 8'h01) ? CRM_D_END : CRM_D_EXEC;
                    end else if (chunk_reg == 3'h1) begin
                        state_next = CRM_D_END;
                    end
                end
            end
            CRM_D_END: begin
                if (fire) begin
                    rsp_valid_next = 1'b1;
                    rsp_ctrl_next = 1'b1;
                    rsp_data_next = `CRM_TOK_END;
                    state_next = CRM_D_IDLE;
                end
            end
        endcase
        req_ready_next = (state_next == CRM_D_HDR)
            || (state_next == CRM_D_IDLE && !(state_reg == CRM_D_IDLE && !link.req_valid && ps_req));
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state_reg <= CRM_D_IDLE;
            buf_reg <= 72'h0;
            cnt_reg <= 4'h0;
            op_reg <= 8'h00;
            bad_reg <= 1'b0;
            ok_reg <= 1'b0;
            ps_reg <= 1'b0;
            left_reg <= 8'h00;
            chunk_reg <= 3'h0;
            rdata_reg <= 32'h0;
            req_ready_reg <= 1'b0;
            rsp_valid_reg <= 1'b0;
            rsp_ctrl_reg <= 1'b0;
            rsp_data_reg <= 8'h00;
            rsp_dest_reg <= 24'h0;
            reg_req_reg <= 1'b0;
            reg_we_reg <= 1'b0;
            reg_class_reg <= CRM_CL_TILE;
            reg_num_reg <= 16'h0;
            reg_wdata_reg <= 32'h0;
            ps_ack_reg <= 1'b0;
            ps_rdata_reg <= 32'h0;
        end else begin
            state_reg <= state_next;
            buf_reg <= buf_next;
            cnt_reg <= cnt_next;
            op_reg <= op_next;
            bad_reg <= bad_next;
            ok_reg <= ok_next;
            ps_reg <= ps_next;
            left_reg <= left_next;
            chunk_reg <= chunk_next;
            rdata_reg <= rdata_next;
            req_ready_reg <= req_ready_next;
            rsp_valid_reg <= rsp_valid_next;
            rsp_ctrl_reg <= rsp_ctrl_next;
            rsp_data_reg <= rsp_data_next;
            rsp_dest_reg <= rsp_dest_next;
            reg_req_reg <= reg_req_next;
            reg_we_reg <= reg_we_next;
            reg_class_reg <= reg_class_next;
            reg_num_reg <= reg_num_next;
            reg_wdata_reg <= reg_wdata_next;
            ps_ack_reg <= ps_ack_next;
            ps_rdata_reg <= ps_rdata_next;
        end
    end

    // ============================================================
    // Outputs
    assign link.req_ready = req_ready_reg;
    assign link.rsp_valid = rsp_valid_reg;
    assign link.rsp_ctrl = rsp_ctrl_reg;
    assign link.rsp_data = rsp_data_reg;
    assign link.rsp_dest = rsp_dest_reg;
    assign reg_req = reg_req_reg;
    assign reg_we = reg_we_reg;
    assign reg_class = reg_class_reg;
    assign reg_num = reg_num_reg;
    assign reg_wdata = reg_wdata_reg;
    assign ps_ack = ps_ack_reg;
    assign ps_rdata = ps_rdata_reg;
endmodule

`default_nettype wire

//--- rtl/crm_link_if.sv
`timescale 1ns/1ps
`default_nettype none

interface crm_link_if (
    input wire logic sys_clk,
    input wire logic reset
);
    logic [31:0] dest;
    logic req_valid;
    logic req_ctrl;
    logic [7:0] req_data;
    logic req_ready;
    logic rsp_valid;
    logic rsp_ctrl;
    logic [7:0] rsp_data;
    logic rsp_ready;
    logic [23:0] rsp_dest;

    modport dev (
        input dest, req_valid, req_ctrl, req_data, rsp_ready,
        output req_ready, rsp_valid, rsp_ctrl, rsp_data, rsp_dest
    );
    modport rqs (
        output dest, req_valid, req_ctrl, req_data, rsp_ready,
        input req_ready, rsp_valid, rsp_ctrl, rsp_data, rsp_dest
    );
endinterface

`default_nettype wire

//--- rtl/crm_params.svh
`ifndef CRM_PARAMS_SVH
`define CRM_PARAMS_SVH

// ============================================================
// Control tokens
`define CRM_TOK_END 8'h01
`define CRM_TOK_ACK 8'h03
`define CRM_TOK_NAK 8'h04
`define CRM_TOK_CFG_WR 8'hc0
`define CRM_TOK_CFG_RD 8'hc1
`define CRM_TOK_PER_RD 8'h25

// ============================================================
// Data byte counts between opening and closing token
`define CRM_LEN_CFG_WR 4'h9
`define CRM_LEN_CFG_RD 4'h5
`define CRM_LEN_PER_RD 4'h5
`define CRM_CNT_MAX 4'hf

// ============================================================
// Destination target codes
`define CRM_DST_TILE 16'hc20c
`define CRM_DST_NODE 16'hc30c
`define CRM_DST_PERI 8'h02
`define CRM_NOREPLY 8'hff

// ============================================================
// Processor status resource type
`define CRM_PS_TYPE 8'h0b
`define CRM_PS_SHIFT 8

`endif

//--- rtl/crm_pkg.sv
package crm_pkg;

    typedef enum logic [1:0] {
        CRM_CL_TILE = 2'h0,
        CRM_CL_NODE = 2'h1,
        CRM_CL_PERI = 2'h2,
        CRM_CL_PS = 2'h3
    } crm_class_t;

    typedef enum logic [1:0] {
        CRM_K_CFG_WR = 2'h0,
        CRM_K_CFG_RD = 2'h1,
        CRM_K_PER_RD = 2'h2
    } crm_kind_t;

    typedef enum logic [6:0] {
        CRM_D_IDLE = 7'h01,
        CRM_D_HDR = 7'h02,
        CRM_D_EXEC = 7'h04,
        CRM_D_WAIT = 7'h08,
        CRM_D_TOK = 7'h10,
        CRM_D_DATA = 7'h20,
        CRM_D_END = 7'h40
    } crm_dstate_t;

    typedef enum logic [4:0] {
        CRM_R_IDLE = 5'h01,
        CRM_R_OPEN = 5'h02,
        CRM_R_BODY = 5'h04,
        CRM_R_CLOSE = 5'h08,
        CRM_R_RESP = 5'h10
    } crm_rstate_t;

endpackage

//--- rtl/crm_requester.sv
`timescale 1ns/1ps
`default_nettype none
`include "crm_params.svh"

module crm_requester (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Link
    crm_link_if.rqs link,
    // Command
    input wire logic cmd_valid,
    input wire crm_pkg::crm_kind_t cmd_kind,
    input wire logic [31:0] cmd_dest,
    input wire logic [23:0] cmd_reply_id,
    input wire logic [15:0] cmd_reg,
    input wire logic [31:0] cmd_wdata,
    input wire logic [7:0] cmd_size,
    output logic cmd_ready,
    // Completion
    output logic done,
    output logic done_ok,
    output logic [31:0] done_data
);
    import crm_pkg::*;

    crm_rstate_t state_reg, state_next;
    logic [71:0] sh_reg, sh_next;
    logic [3:0] n_reg, n_next;
    logic [7:0] op_reg, op_next;
    logic noreply_reg, noreply_next;
    logic [31:0] dest_reg, dest_next;
    logic req_valid_reg, req_valid_next;
    logic req_ctrl_reg, req_ctrl_next;
    logic [7:0] req_data_reg, req_data_next;
    logic rsp_ready_reg, rsp_ready_next;
    logic cmd_ready_reg, cmd_ready_next;
    logic done_reg, done_next;
    logic ok_reg, ok_next;
    logic [31:0] data_reg, data_next;
    logic fire;
    logic rx;

    // ============================================================
    // Message build and reply collection
    always_comb begin
        state_next = state_reg;
        sh_next = sh_reg;
        n_next = n_reg;
        op_next = op_reg;
        noreply_next = noreply_reg;
        dest_next = dest_reg;
        req_valid_next = req_valid_reg & ~link.req_ready;
        req_ctrl_next = req_ctrl_reg;
        req_data_next = req_data_reg;
        done_next = 1'b0;
        ok_next = ok_reg;
        data_next = data_reg;
        fire = ~req_valid_reg | link.req_ready;
        rx = link.rsp_valid & rsp_ready_reg;
        unique case (state_reg)
            CRM_R_IDLE: begin
                if (cmd_valid) begin
                    dest_next = cmd_dest;
                    unique case (cmd_kind)
                        CRM_K_CFG_WR: begin
                            op_next = `CRM_TOK_CFG_WR;
                            sh_next = {cmd_reply_id, cmd_reg, cmd_wdata};
                            n_next = `CRM_LEN_CFG_WR;
                        end
                        CRM_K_CFG_RD: begin
                            op_next = `CRM_TOK_CFG_RD;
                            sh_next = {cmd_reply_id, cmd_reg, 32'h0};
                            n_next = `CRM_LEN_CFG_RD;
                        end
                        default: begin
                            op_next = `CRM_TOK_PER_RD;
                            sh_next = {cmd_reply_id, cmd_reg[7:0], cmd_size, 32'h0};
                            n_next = `CRM_LEN_PER_RD;
                        end
                    endcase
                    noreply_next = (cmd_kind == CRM_K_CFG_WR)
                        && (cmd_reply_id[7:0] == `CRM_NOREPLY);
                    state_next = CRM_R_OPEN;
                end
            end
            CRM_R_OPEN: begin
                if (fire) begin
                    req_valid_next = 1'b1;
                    req_ctrl_next = 1'b1;
                    req_data_next = op_reg;
                    state_next = CRM_R_BODY;
                end
            end
            CRM_R_BODY: begin
                if (fire) begin
                    req_valid_next = 1'b1;
                    req_ctrl_next = 1'b0;
                    req_data_next = sh_reg[71:64];
                    sh_next = {sh_reg[63:0], 8'h00};
                    n_next = n_reg - 4'h1;
                    if (n_reg == 4'h1) begin
                        state_next = CRM_R_CLOSE;
                    end
                end
            end
            CRM_R_CLOSE: begin
                if (fire) begin
                    req_valid_next = 1'b1;
                    req_ctrl_next = 1'b1;
                    req_data_next = `CRM_TOK_END;
                    ok_next = noreply_reg;
                    data_next = 32'h0;
                    if (noreply_reg) begin
                        done_next = 1'b1;
                        state_next = CRM_R_IDLE;
                    end else begin
                        state_next = CRM_R_RESP;
                    end
                end
            end
            CRM_R_RESP: begin
                if (rx && link.rsp_ctrl && link.rsp_data == `CRM_TOK_END) begin
                    done_next = 1'b1;
                    state_next = CRM_R_IDLE;
                end else if (rx && link.rsp_ctrl) begin
                    ok_next = (link.rsp_data == `CRM_TOK_ACK);
                end else if (rx) begin
                    data_next = {data_reg[23:0], link.rsp_data};
                end
            end
        endcase
        rsp_ready_next = (state_next == CRM_R_RESP);
        cmd_ready_next = (state_next == CRM_R_IDLE);
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state_reg <= CRM_R_IDLE;
            sh_reg <= 72'h0;
            n_reg <= 4'h0;
            op_reg <= 8'h00;
            noreply_reg <= 1'b0;
            dest_reg <= 32'h0;
            req_valid_reg <= 1'b0;
            req_ctrl_reg <= 1'b0;
            req_data_reg <= 8'h00;
            rsp_ready_reg <= 1'b0;
            cmd_ready_reg <= 1'b0;
            done_reg <= 1'b0;
            ok_reg <= 1'b0;
            data_reg <= 32'h0;
        end else begin
            state_reg <= state_next;
            sh_reg <= sh_next;
            n_reg <= n_next;
            op_reg <= op_next;
            noreply_reg <= noreply_next;
            dest_reg <= dest_next;
            req_valid_reg <= req_valid_next;
            req_ctrl_reg <= req_ctrl_next;
            req_data_reg <= req_data_next;
            rsp_ready_reg <= rsp_ready_next;
            cmd_ready_reg <= cmd_ready_next;
            done_reg <= done_next;
            ok_reg <= ok_next;
            data_reg <= data_next;
        end
    end

    // ============================================================
    // Outputs
    assign link.dest = dest_reg;
    assign link.req_valid = req_valid_reg;
    assign link.req_ctrl = req_ctrl_reg;
    assign link.req_data = req_data_reg;
    assign link.rsp_ready = rsp_ready_reg;
    assign cmd_ready = cmd_ready_reg;
    assign done = done_reg;
    assign done_ok = ok_reg;
    assign done_data = data_reg;
endmodule

`default_nettype wire

//--- test/config_register_message_access_bench.sv
`timescale 1ns/1ps
`default_nettype none
module config_register_message_access_bench;
    import crm_pkg::*;
    logic sys_clk = 0, reset = 1, cmd_valid = 0, reg_ack = 0, reg_ok = 0;
    logic ps_req = 0, ps_we = 0, cmd_ready, done, done_ok, reg_req, reg_we, ps_ack;
    crm_kind_t cmd_kind = CRM_K_CFG_WR;
    crm_class_t reg_class;
    logic [31:0] cmd_dest = 0, cmd_wdata = 0, reg_rdata = 0, ps_wdata = 0;
    logic [31:0] done_data, reg_wdata, ps_rdata, seed = 32'hebda3e44, e_word, x;
    logic [23:0] cmd_reply_id = 0;
    logic [15:0] cmd_reg = 0, reg_num;
    logic [7:0] cmd_size = 0, ps_num = 0;
    logic [18:0] e_acc;
    int n_errors = 0, comparisons = 0, n_acc, i;
    always #5 sys_clk = ~sys_clk;
    crm_link_if link (.sys_clk, .reset);
    crm_device i_crm_device (.sys_clk, .reset, .link, .reg_req, .reg_we, .reg_class,
        .reg_num, .reg_wdata, .reg_ack, .reg_ok, .reg_rdata, .ps_req, .ps_we, .ps_num,
        .ps_wdata, .ps_ack, .ps_rdata);
    crm_requester i_crm_requester (.sys_clk, .reset, .link, .cmd_valid, .cmd_kind,
        .cmd_dest, .cmd_reply_id, .cmd_reg, .cmd_wdata, .cmd_size, .cmd_ready, .done,
        .done_ok, .done_data);
    crm_link_properties i_crm_link_properties (.sys_clk, .reset, .dest(link.dest),
        .req_valid(link.req_valid), .req_ctrl(link.req_ctrl), .req_data(link.req_data),
        .req_ready(link.req_ready), .rsp_valid(link.rsp_valid), .rsp_ctrl(link.rsp_ctrl),
        .rsp_data(link.rsp_data), .rsp_ready(link.rsp_ready), .rsp_dest(link.rsp_dest));
    // ==========
    // Model
    function automatic logic [31:0] rd(logic [15:0] n);
        return {n ^ 16'h5a3c, n};
    endfunction
    function automatic logic okf(logic [15:0] n);
        return n[3:0] != 4'hf;
    endfunction
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task report_and_stop;
        $display("comparisons %0d, mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task check(input logic [31:0] s, e);
        comparisons++;
        if (s !== e) begin
            n_errors++;
            $display("mismatch at %0t: %h not %h", $time, s, e);
        end
    endtask
    task until_high(input int w);
        int k;
        for (k = 0; k < 300; k++) begin
            @(posedge sys_clk);
            #1;
            if ((w == 0 ? cmd_ready : w == 1 ? done : w == 2 ? ps_ack : reg_ack) === 1'b1)
                break;
        end
        if (k == 300) begin
            n_errors++;
            $display("mismatch at %0t: timeout", $time);
            report_and_stop();
        end
    endtask
    // ==========
    // Register side
    always @(posedge sys_clk) begin
        reg_ack <= reg_req;
        if (reg_req === 1'b1) begin
            reg_ok <= okf(reg_num);
            reg_rdata <= rd(reg_num);
            n_acc++;
            check({reg_class, reg_we, reg_num}, e_acc);
            if (reg_we) check(reg_wdata, e_word);
            e_acc[15:0]++;
        end
    end
    // ==========
    // Commands
    task run_cmd(input crm_kind_t k, input logic [31:0] d, input logic [23:0] id,
        input logic [15:0] r, input logic [31:0] w, input logic [7:0] n);
        logic tile, node, tgt, ok, pr, nr;
        logic [31:0] dd, t, m;
        logic [15:0] rr;
        tile = d[15:0] == 16'hc20c;
        node = d[15:0] == 16'hc30c;
        pr = k == CRM_K_PER_RD;
        rr = pr ? {8'h00, r[7:0]} : r;
        tgt = pr ? !tile && !node && d[7:0] == 8'h02 : tile || node;
        if (!tgt) id[0] = 1'b0;
        nr = k == CRM_K_CFG_WR && id[7:0] == 8'hff;
        ok = tgt && okf(rr);
        dd = rd(rr);
        for (int a = 0; pr && a < n; a++) begin
            t = rd(rr + 16'(a));
            dd = {dd[23:0], t[7:0]};
        end
        m = !pr || n >= 4 ? 32'hffffffff : (32'h1 << (8 * n)) - 32'h1;
        until_high(0);
        e_acc = {tile ? CRM_CL_TILE : node ? CRM_CL_NODE : CRM_CL_PERI, !pr && !k[0], rr};
        e_word = w;
        n_acc = 0;
        cmd_kind = k;
        {cmd_valid, cmd_dest, cmd_reply_id, cmd_reg, cmd_wdata, cmd_size} =
            {1'b1, d, id, r, w, n};
        @(posedge sys_clk);
        #1 cmd_valid = 0;
        until_high(1);
        if (nr) until_high(3);
        check(done_ok, nr || ok);
        if (ok && k != CRM_K_CFG_WR) check(done_data & m, dd & m);
        if (!nr) check(link.rsp_dest, id);
        if (ok || !pr) check(n_acc, !tgt ? 0 : pr && n != 0 ? n : 1);
    endtask
    initial begin
        repeat (20) @(posedge sys_clk);
        #1 reset = 0;
        run_cmd(CRM_K_CFG_WR, 32'h0001c20c, 24'h1234ff, 16'h0010, 32'hcafe0001, 0);
        run_cmd(CRM_K_PER_RD, 32'h00010502, 24'h123400, 16'h0040, 0, 4);
        run_cmd(CRM_K_PER_RD, 32'h00010502, 24'h123401, 16'h0041, 0, 0);
        $display("test directed done");
        for (i = 0; i < 40; i++) begin
            x = xs();
            run_cmd(crm_kind_t'(x[1:0] % 3), {x[31:16], x[3:2] == 0 ? 16'hc20c :
                x[3:2] == 1 ? 16'hc30c : x[3:2] == 2 ? {x[15:8], 8'h02} : 16'h1234},
                {x[23:8], x[6:4] == 0 ? 8'hff : x[15:8]}, 16'(xs() & 32'hff7f), xs(),
                8'(x[12:8] % 6 + 1));
        end
        $display("test random done");
        for (i = 0; i < 4; i++) begin
            x = xs();
            {ps_num, ps_we, ps_wdata} = {x[7:0], x[8], xs()};
            e_acc = {CRM_CL_PS, x[8], x[7:0], 8'h0b};
            e_word = ps_wdata;
            n_acc = 0;
            ps_req = 1;
            until_high(2);
            ps_req = 0;
            check(n_acc, 1);
            if (!x[8]) check(ps_rdata, rd({x[7:0], 8'h0b}));
            #10;
        end
        $display("test status done");
        report_and_stop();
    end
endmodule
`default_nettype wire

//--- test/crm_link_properties.sv
`timescale 1ns/1ps
`default_nettype none
module crm_link_properties (
    // Link
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [31:0] dest,
    input wire logic req_valid,
    input wire logic req_ctrl,
    input wire logic [7:0] req_data,
    input wire logic req_ready,
    input wire logic rsp_valid,
    input wire logic rsp_ctrl,
    input wire logic [7:0] rsp_data,
    input wire logic rsp_ready,
    input wire logic [23:0] rsp_dest
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    wire cls = req_valid && req_ready && req_ctrl && req_data == 8'h01;
    wire tok = rsp_valid && rsp_ready && rsp_ctrl;
    wire bad = dest[15:0] != 16'hc20c && dest[15:0] != 16'hc30c && dest[7:0] != 8'h02;
    // Last opener was a configuration write
    logic wr;
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) wr <= 1'b0;
        else if (req_valid && req_ready && req_ctrl && req_data != 8'h01)
            wr <= req_data == 8'hc0;
    end
    property p_req_hold;
        req_valid && !req_ready |=> req_valid && $stable({req_ctrl, req_data});
    endproperty
    a_req_hold: assert property (p_req_hold) else $error("request moved");
    property p_rsp_hold;
        rsp_valid && !rsp_ready |=> rsp_valid && $stable({rsp_ctrl, rsp_data});
    endproperty
    a_rsp_hold: assert property (p_rsp_hold) else $error("reply moved");
    property p_rsp_tok;
        rsp_valid && rsp_ctrl |-> rsp_data inside {8'h01, 8'h03, 8'h04};
    endproperty
    a_rsp_tok: assert property (p_rsp_tok) else $error("bad token");
    property p_quiet;
        rsp_valid |-> !(wr && rsp_dest[7:0] == 8'hff);
    endproperty
    a_quiet: assert property (p_quiet) else $error("reply sent");
    property p_close;
        cls |=> !req_ready;
    endproperty
    a_close: assert property (p_close) else $error("ready after close");
    property p_nak;
        tok && rsp_data == 8'h04 |=> rsp_valid && rsp_ctrl && rsp_data == 8'h01;
    endproperty
    a_nak: assert property (p_nak) else $error("no end after 4");
    property p_bad;
        cls && bad |-> (##1 rsp_dest[7:0] == 8'hff)
            or (##[1:3] rsp_valid && rsp_ctrl && rsp_data == 8'h04);
    endproperty
    a_bad: assert property (p_bad) else $error("bad target");
    property p_apart;
        req_valid && req_ready |-> !rsp_valid;
    endproperty
    a_apart: assert property (p_apart) else $error("overlap");
    property p_free;
        tok && rsp_data == 8'h01 |-> ##[0:2] req_ready;
    endproperty
    a_free: assert property (p_free) else $error("ready late");
endmodule
`default_nettype wire
